// >>> src/oiu_pkg.sv
// package: constants and types for the output image unpack and event clear block
package oiu_pkg;
  localparam int           DATA_MAX_BYTES    = 32;           // data area ceiling in bytes
  localparam logic [5:0]   DATA_LEN_RST      = 6'h20;        // default data area length
  localparam int           IMG_BYTES         = 36;           // data plus two optional fields
  localparam logic [1:0]   FMT_8             = 2'h0;
  localparam logic [1:0]   FMT_16            = 2'h1;
  localparam logic [1:0]   FMT_32            = 2'h2;
  localparam int           DO_IN_BIT         = 1;            // input line setting, byte/word formats
  localparam int           DO_CQ_BIT         = 3;            // combined line setting, byte/word formats
  localparam int           DO32_IN_BIT       = 17;           // input line setting, long word format
  localparam int           DO32_CQ_BIT       = 19;           // combined line setting, long word format
  localparam logic [15:0]  EVT_NONE          = 16'h0000;
  localparam int           EVT_WORD_BYTE     = 2;            // event code position in 8-bit input image
  localparam int           CLK_MHZ           = 100;
  localparam int           HOLD_UNIT_US      = 1000;         // hold times are set in milliseconds
  localparam int           CYC_PER_MS        = HOLD_UNIT_US * CLK_MHZ;
  localparam logic [15:0]  ACT_HOLD_MS_RST   = 16'h03E8;     // arbitrary plain default
  localparam logic [15:0]  CLR_HOLD_MS_RST   = 16'h03E8;     // arbitrary plain default
  typedef enum logic [2:0] {
    OIU_IDLE   = 3'b001,
    OIU_ACTIVE = 3'b010,
    OIU_CLRHLD = 3'b100
  } oiu_state_e;
endpackage : oiu_pkg

// >>> src/oiu_evt_if.sv
// interface: event and clear request path between unpacker, clear engine and top
`timescale 1ns/100ps
`default_nettype none
interface oiu_evt_if;
  logic        img_stb;   // one output image with clear field taken this cycle
  logic [15:0] clr_code;  // code to clear carried in that image
  logic        evt_stb;   // new event code from the field device
  logic [15:0] evt_code;
  logic [15:0] shown;     // code presented in the input image
  modport unpack (output img_stb, output clr_code);
  modport engine (input img_stb, input clr_code, input evt_stb, input evt_code, output shown);
  modport top    (output evt_stb, output evt_code, input shown);
endinterface : oiu_evt_if
`default_nettype wire

// >>> src/oiu_unpack.sv
// module: splits an output image into clear code, digital settings and device data
`timescale 1ns/100ps
`default_nettype none
module oiu_unpack (
  input  wire logic                                i_clk,
  input  wire logic                                i_nrst,
  input  wire logic                                i_img_vld,
  input  wire logic [oiu_pkg::IMG_BYTES*8-1:0]     i_img,
  input  wire logic [1:0]                          i_fmt,
  input  wire logic                                i_clr_fld_en,
  input  wire logic                                i_dig_fld_en,
  input  wire logic [5:0]                          i_data_len,
  oiu_evt_if.unpack                                evt,
  output logic                                     o_data_vld,
  output logic [oiu_pkg::DATA_MAX_BYTES*8-1:0]     o_data,
  output logic                                     o_second_digital_pin,
  output logic                                     o_fourth_digital_pin
);
  typedef struct packed {
    logic                                   vld;
    logic [oiu_pkg::DATA_MAX_BYTES*8-1:0]   data;
    logic                                   pin2;
    logic                                   pin4;
  } oiu_unp_s;
  oiu_unp_s st_r;
  oiu_unp_s st_nxt;
  logic [5:0]  skip;       // leading bytes before the data area
  logic [15:0] code;
  logic [31:0] word0;
  logic [5:0]  len;

  // leading field size depends on element width and options
  always_comb begin
    word0 = i_img[31:0];
    code  = i_clr_fld_en ? word0[15:0] : oiu_pkg::EVT_NONE;
    skip  = 6'h00;
    if (i_clr_fld_en) begin
      case (i_fmt)
        oiu_pkg::FMT_8:  skip = i_dig_fld_en ? 6'h04 : 6'h02;
        oiu_pkg::FMT_16: skip = i_dig_fld_en ? 6'h04 : 6'h02;
        default:         skip = 6'h04;
      endcase
    end
    len = (i_data_len > 6'h20) ? 6'h20 : i_data_len;
  end

  // register the split fields; padding byte and stray setting bits are ignored
  always_comb begin
    st_nxt     = st_r;
    st_nxt.vld = i_img_vld;
    if (i_img_vld) begin
      for (int b = 0; b < oiu_pkg::DATA_MAX_BYTES; b++) begin
        st_nxt.data[b*8 +: 8] = (6'(b) < len) ? i_img[(int'(skip) + b)*8 +: 8] : 8'h00;
      end
      if (i_clr_fld_en && i_dig_fld_en) begin
        if (i_fmt == oiu_pkg::FMT_32) begin
          st_nxt.pin2 = word0[oiu_pkg::DO32_IN_BIT];
          st_nxt.pin4 = word0[oiu_pkg::DO32_CQ_BIT];
        end else begin
          st_nxt.pin2 = word0[16 + oiu_pkg::DO_IN_BIT];
          st_nxt.pin4 = word0[16 + oiu_pkg::DO_CQ_BIT];
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt.img_stb          = i_img_vld & i_clr_fld_en;
  assign evt.clr_code         = code;
  assign o_data_vld           = st_r.vld;
  assign o_data               = st_r.data;
  assign o_second_digital_pin = st_r.pin2;
  assign o_fourth_digital_pin = st_r.pin4;
endmodule : oiu_unpack
`default_nettype wire

// >>> src/oiu_clear.sv
// module: event code presentation with timed and image driven clearing
`timescale 1ns/100ps
`default_nettype none
module oiu_clear #(
  parameter int unsigned CYC_PER_MS = oiu_pkg::CYC_PER_MS
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_timed_en,
  input  wire logic        i_img_clr_en,
  input  wire logic [15:0] i_act_hold_ms,
  input  wire logic [15:0] i_clr_hold_ms,
  oiu_evt_if.engine        evt,
  output logic             o_cleared
);
  typedef struct packed {
    oiu_pkg::oiu_state_e state;
    logic [15:0]         shown;
    logic [15:0]         pend;
    logic [16:0]         pre;   // cycles within one millisecond
    logic [15:0]         ms;
    logic                clr;
  } oiu_clr_s;
  oiu_clr_s st_r;
  oiu_clr_s st_nxt;
  logic tick;
  logic new_evt;
  logic img_match;

  assign tick      = (st_r.pre == 17'(CYC_PER_MS - 1));
  assign new_evt   = evt.evt_stb && (evt.evt_code != oiu_pkg::EVT_NONE);
  // zero code never clears, and only an active equal code does
  assign img_match = i_img_clr_en && evt.img_stb && (evt.clr_code != oiu_pkg::EVT_NONE)
                     && (evt.clr_code == st_r.shown);

  always_comb begin
    st_nxt     = st_r;
    st_nxt.clr = 1'b0;
    st_nxt.pre = tick ? 17'h00000 : st_r.pre + 17'h00001;
    if (tick) begin
      st_nxt.ms = st_r.ms + 16'h0001;
    end
    case (st_r.state)
      oiu_pkg::OIU_IDLE: begin
        if (new_evt) begin
          st_nxt.state = oiu_pkg::OIU_ACTIVE;
          st_nxt.shown = evt.evt_code;
          st_nxt.pre   = 17'h00000;
          st_nxt.ms    = 16'h0000;
        end
      end
      oiu_pkg::OIU_ACTIVE: begin
        if (new_evt) begin
          st_nxt.shown = evt.evt_code; // newer device code replaces it, hold unchanged
        end
        // either method may fire first; both lead to the same clear hold
        if (img_match || (i_timed_en && st_r.ms >= i_act_hold_ms)) begin
          st_nxt.state = oiu_pkg::OIU_CLRHLD;
          st_nxt.shown = oiu_pkg::EVT_NONE;
          st_nxt.pend  = oiu_pkg::EVT_NONE;
          st_nxt.clr   = 1'b1;
          st_nxt.pre   = 17'h00000;
          st_nxt.ms    = 16'h0000;
        end
      end
      oiu_pkg::OIU_CLRHLD: begin
        if (new_evt) begin
          st_nxt.pend = evt.evt_code;
        end
        if (st_r.ms >= i_clr_hold_ms) begin
          st_nxt.pre   = 17'h00000;
          st_nxt.ms    = 16'h0000;
          if (new_evt || st_r.pend != oiu_pkg::EVT_NONE) begin
            st_nxt.state = oiu_pkg::OIU_ACTIVE;
            st_nxt.shown = new_evt ? evt.evt_code : st_r.pend;
            st_nxt.pend  = oiu_pkg::EVT_NONE;
          end else begin
            st_nxt.state = oiu_pkg::OIU_IDLE;
          end
        end
      end
      default: begin
        st_nxt.state = oiu_pkg::OIU_IDLE;
        st_nxt.shown = oiu_pkg::EVT_NONE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '{state: oiu_pkg::OIU_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt.shown = st_r.shown;
  assign o_cleared = st_r.clr;
endmodule : oiu_clear
`default_nettype wire

// >>> src/oiu_top.sv
// module: top of output image unpack and event clear with register port and interrupt
// Function
// - device data area is 0 to 32 bytes, default length 32.
// - optional clear field carries a 16-bit code to clear.
// - optional digital field drives the two digital output pins when the clear field is also present.
// - with no options, data element k sits at image element k.
// - 8-bit format: code bytes 0-1, settings byte 2, pad byte 3.
// - 16-bit format: code word 0, settings word 1 when present.
// - 32-bit format, clear only: code in low half, data from word 1.
// - 32-bit both options: settings at bits 17 and 19 of word 0.
// - field device event code shown in input image, zero means none.
// - timed clearing zeroes an active code after the active hold time.
// - after a timed clear the code stays zero for clear hold time.
// - image clearing zeroes the code when active and equal.
// - after an image clear the code stays zero for clear hold time.
// - both methods may be enabled together; first condition wins.
// - 8-bit input image puts the code at bytes 2 and 3, low first.
`timescale 1ns/100ps
`default_nettype none
module oiu_top #(
  parameter int unsigned CYC_PER_MS = oiu_pkg::CYC_PER_MS
) (
  input  wire logic                                 i_clk,
  input  wire logic                                 i_nrst,
  input  wire logic [3:0]                           i_addr,
  input  wire logic [31:0]                          i_wdata,
  input  wire logic                                 i_wr,
  input  wire logic                                 i_rd,
  output logic      [31:0]                          o_rdata,
  input  wire logic                                 i_img_vld,
  input  wire logic [oiu_pkg::IMG_BYTES*8-1:0]      i_img,
  input  wire logic                                 i_evt_vld,
  input  wire logic [15:0]                          i_evt_code,
  output logic                                      o_data_vld,
  output logic      [oiu_pkg::DATA_MAX_BYTES*8-1:0] o_data,
  output logic                                      o_second_digital_pin,
  output logic                                      o_fourth_digital_pin,
  output logic      [15:0]                          o_evt_code,
  output logic      [31:0]                          o_evt_word,
  output logic                                      o_irq
);
  localparam logic [3:0] A_CFG  = 4'h0; // format, options, data length
  localparam logic [3:0] A_HOLD = 4'h1; // active hold ms low, clear hold ms high
  localparam logic [3:0] A_EVT  = 4'h2; // event code presented
  localparam logic [3:0] A_STAT = 4'h3; // sticky events, cleared by read
  localparam logic [3:0] A_MASK = 4'h4;

  typedef struct packed {
    logic [1:0]  fmt;
    logic        clr_fld;
    logic        dig_fld;
    logic        timed_en;
    logic        img_clr_en;
    logic [5:0]  len;
    logic [15:0] act_ms;
    logic [15:0] clr_ms;
    logic [2:0]  stat;   // 0 new event, 1 cleared, 2 image taken
    logic [2:0]  mask;
    logic [31:0] rdata;
    logic [15:0] last_shown;
  } oiu_top_s;
  oiu_top_s st_r;
  oiu_top_s st_nxt;
  logic [2:0] ev;
  logic       cleared;

  oiu_evt_if evt ();

  assign evt.evt_stb  = i_evt_vld;
  assign evt.evt_code = i_evt_code;

  oiu_unpack u_unpack (
    .i_clk                (i_clk),
    .i_nrst               (i_nrst),
    .i_img_vld            (i_img_vld),
    .i_img                (i_img),
    .i_fmt                (st_r.fmt),
    .i_clr_fld_en         (st_r.clr_fld),
    .i_dig_fld_en         (st_r.dig_fld),
    .i_data_len           (st_r.len),
    .evt                  (evt.unpack),
    .o_data_vld           (o_data_vld),
    .o_data               (o_data),
    .o_second_digital_pin (o_second_digital_pin),
    .o_fourth_digital_pin (o_fourth_digital_pin)
  );

  oiu_clear #(.CYC_PER_MS(CYC_PER_MS)) u_clear (
    .i_clk         (i_clk),
    .i_nrst        (i_nrst),
    .i_timed_en    (st_r.timed_en),
    .i_img_clr_en  (st_r.img_clr_en),
    .i_act_hold_ms (st_r.act_ms),
    .i_clr_hold_ms (st_r.clr_ms),
    .evt           (evt.engine),
    .o_cleared     (cleared)
  );

  assign ev = {i_img_vld, cleared,
               (evt.shown != st_r.last_shown) && (evt.shown != oiu_pkg::EVT_NONE)};

  // register writes, reads and sticky status; a new event beats a read clear
  always_comb begin
    st_nxt            = st_r;
    st_nxt.rdata      = 32'h00000000;
    st_nxt.last_shown = evt.shown;
    if (i_wr) begin
      case (i_addr)
        A_CFG: begin
          st_nxt.fmt        = i_wdata[1:0];
          st_nxt.clr_fld    = i_wdata[4];
          st_nxt.dig_fld    = i_wdata[5];
          st_nxt.timed_en   = i_wdata[6];
          st_nxt.img_clr_en = i_wdata[7];
          st_nxt.len        = (i_wdata[13:8] > oiu_pkg::DATA_LEN_RST) ? oiu_pkg::DATA_LEN_RST
                                                                      : i_wdata[13:8];
        end
        A_HOLD: begin
          st_nxt.act_ms = i_wdata[15:0];
          st_nxt.clr_ms = i_wdata[31:16];
        end
        A_MASK:  st_nxt.mask = i_wdata[2:0];
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        A_CFG:   st_nxt.rdata = {18'h00000, st_r.len, st_r.img_clr_en, st_r.timed_en,
                                 st_r.dig_fld, st_r.clr_fld, 2'h0, st_r.fmt};
        A_HOLD:  st_nxt.rdata = {st_r.clr_ms, st_r.act_ms};
        A_EVT:   st_nxt.rdata = {16'h0000, evt.shown};
        A_STAT: begin
          st_nxt.rdata = {29'h0000000, st_r.stat};
          st_nxt.stat  = 3'h0;
        end
        A_MASK:  st_nxt.rdata = {29'h0000000, st_r.mask};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
    st_nxt.stat = st_nxt.stat | ev;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '{len: oiu_pkg::DATA_LEN_RST, act_ms: oiu_pkg::ACT_HOLD_MS_RST,
                clr_ms: oiu_pkg::CLR_HOLD_MS_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // 8-bit input image view: code low byte at byte 2, high at byte 3
  assign o_evt_code = evt.shown;
  assign o_evt_word = {evt.shown[15:8], evt.shown[7:0], 16'h0000};
  assign o_rdata    = st_r.rdata;
  assign o_irq      = |(st_r.stat & st_r.mask);
endmodule : oiu_top
`default_nettype wire

// >>> test/oiu_ctl_model.sv
// controller model: builds output images in every layout and sends them
`timescale 1ns/100ps
`default_nettype none
module oiu_ctl_model (
  input  wire logic                             i_clk,
  output logic                                  o_img_vld,
  output logic [oiu_pkg::IMG_BYTES*8-1:0]       o_img
);
  initial begin
    o_img_vld = 1'b0;
    o_img     = '0;
  end
  // pack code, settings and data; the released image shows the inverse, not the old value
  task automatic send(input logic [1:0] f, input logic ce, input logic de, input logic [15:0] c,
                      input logic [1:0] dg, input logic [255:0] d);
    logic [287:0] m;
    int           off;
    m   = '0;
    off = 0;
    if (ce) begin
      m[15:0] = c;
      off = (de || f == oiu_pkg::FMT_32) ? 4 : 2;
      if (de) begin
        m[31:16] = 16'($urandom());
        m[17]    = dg[0];
        m[19]    = dg[1];
      end
    end
    m = m | ({32'h0, d} << (off * 8));
    @(posedge i_clk);
    o_img     <= m;
    o_img_vld <= 1'b1;
    @(posedge i_clk);
    o_img_vld <= 1'b0;
    o_img     <= ~m;
  endtask : send
endmodule : oiu_ctl_model
`default_nettype wire

// >>> test/oiu_properties.sv
// checker: port level properties of the unpack and event clear top
`timescale 1ns/100ps
`default_nettype none
module oiu_properties #(
  parameter int unsigned CYC_PER_MS = oiu_pkg::CYC_PER_MS
) (
  input wire logic          i_clk,
  input wire logic          i_nrst,
  input wire logic          i_rd,
  input wire logic          i_img_vld,
  input wire logic          i_evt_vld,
  input wire logic [15:0]   i_evt_code,
  input wire logic [31:0]   o_rdata,
  input wire logic          o_data_vld,
  input wire logic [255:0]  o_data,
  input wire logic          o_second_digital_pin,
  input wire logic          o_fourth_digital_pin,
  input wire logic [15:0]   o_evt_code,
  input wire logic [31:0]   o_evt_word
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_data_vld; i_img_vld |=> o_data_vld; endproperty
  a_data_vld: assert property (p_data_vld) else $error("data valid missing");
  property p_no_vld; !i_img_vld |=> !o_data_vld; endproperty
  a_no_vld: assert property (p_no_vld) else $error("data valid without image");
  property p_data_hold; !i_img_vld |=> $stable(o_data); endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved without image");
  property p_pin_hold;
    !i_img_vld |=> $stable({o_second_digital_pin, o_fourth_digital_pin});
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pins moved without image");
  property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_word_lo; o_evt_word[15:0] == 16'h0; endproperty
  a_word_lo: assert property (p_word_lo) else $error("status bytes not zero");
  property p_word_hi; o_evt_word[31:16] == o_evt_code; endproperty
  a_word_hi: assert property (p_word_hi) else $error("code bytes misplaced");
  // a shown code may only be replaced by a fresh nonzero field device code
  property p_replace;
    ($changed(o_evt_code) && o_evt_code != 16'h0 && $past(o_evt_code) != 16'h0)
      |-> $past(i_evt_vld) && $past(i_evt_code) == o_evt_code;
  endproperty
  a_replace: assert property (p_replace) else $error("shown code replaced without cause");
  c_img: cover property (i_img_vld ##1 o_data_vld);
  c_evt: cover property (i_evt_vld ##1 o_evt_code != 16'h0);
  c_clr: cover property (o_evt_code != 16'h0 ##1 o_evt_code == 16'h0);
endmodule : oiu_properties
bind oiu_top oiu_properties #(.CYC_PER_MS(CYC_PER_MS)) i_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_rd(i_rd), .i_img_vld(i_img_vld), .i_evt_vld(i_evt_vld),
  .i_evt_code(i_evt_code), .o_rdata(o_rdata), .o_data_vld(o_data_vld), .o_data(o_data),
  .o_second_digital_pin(o_second_digital_pin), .o_fourth_digital_pin(o_fourth_digital_pin),
  .o_evt_code(o_evt_code), .o_evt_word(o_evt_word));
`default_nettype wire

// >>> test/tb_top.sv
// testbench: layouts, event clearing, interrupt and register checks
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_evt_vld = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, o_evt_word, q;
  logic [15:0] i_evt_code = 16'h0, o_evt_code;
  logic [287:0] i_img;
  logic [255:0] o_data, d;
  logic i_img_vld, o_data_vld, o_pin2, o_pin4, o_irq;
  int error_cnt = 0, compares = 0, n, len;
  // clock at 100 MHz
  always #5 i_clk = ~i_clk;
  oiu_ctl_model i_ctl (.i_clk(i_clk), .o_img_vld(i_img_vld), .o_img(i_img));
  oiu_top #(.CYC_PER_MS(10)) i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_img_vld(i_img_vld),
    .i_img(i_img), .i_evt_vld(i_evt_vld), .i_evt_code(i_evt_code), .o_data_vld(o_data_vld),
    .o_data(o_data), .o_second_digital_pin(o_pin2), .o_fourth_digital_pin(o_pin4),
    .o_evt_code(o_evt_code), .o_evt_word(o_evt_word), .o_irq(o_irq));
  task automatic test_done();
    $display("tests done: %0d compares, %0d errors", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 q = o_rdata;
  endtask : rd
  task automatic evt(input logic [15:0] c);
    @(posedge i_clk);
    i_evt_vld <= 1'b1; i_evt_code <= c;
    @(posedge i_clk);
    i_evt_vld <= 1'b0;
    #1;
  endtask : evt
  // count cycles until the shown code is zero (z) or nonzero; a hang ends the run
  task automatic wait_code(input logic z);
    for (n = 0; (o_evt_code == 16'h0) !== z; n++) begin
      if (n > 200) begin
        error_cnt++;
        test_done();
      end
      @(posedge i_clk); #1;
    end
  endtask : wait_code
  function automatic logic [255:0] keep(input logic [255:0] v, input int l);
    return v & ({256{1'b1}} >> (256 - 8 * l));
  endfunction : keep
  initial begin
    void'($urandom(23136));
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(4'h0); chk(q, 32'h0000_2000);
    rd(4'h1); chk(q, 32'h03E8_03E8);
    rd(4'h7); chk(q, 32'h0);
    // an oversized length must be clamped to the data area ceiling
    wr(4'h0, 32'h0000_3F00); rd(4'h0); chk(q, 32'h0000_2000);
    $display("test registers done");
    // every format against no option, clear only and both options, random length and data
    for (int f = 0; f < 3; f++) for (int o = 0; o < 3; o++) begin
      len = $urandom_range(32, 0);
      d = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(), $urandom(),
           $urandom(), $urandom()};
      q[1:0] = 2'($urandom());
      wr(4'h0, 32'(f) | (o > 0 ? 32'h10 : 32'h0) | (o > 1 ? 32'h20 : 32'h0) | (len << 8));
      i_ctl.send(2'(f), o > 0, o > 1, 16'h0, q[1:0], d);
      #1 chk(o_data_vld, 1'b1);
      chk(o_data, keep(d, len));
      if (o > 1) chk({o_pin4, o_pin2}, q[1:0]);
    end
    $display("test layouts done");
    wr(4'h1, 32'h0002_0003);
    wr(4'h0, 32'h0000_2040);
    evt(16'hA5C3); chk(o_evt_word, 32'hA5C3_0000);
    evt(16'hB00B); chk(o_evt_code, 16'hB00B);
    wait_code(1'b1); chk(n >= 28 && n <= 34, 1'b1);
    evt(16'h1111); evt(16'h2222); chk(o_evt_code, 16'h0);
    wait_code(1'b0); chk(o_evt_code, 16'h2222);
    chk(n >= 12 && n <= 20, 1'b1);
    $display("test timed clear done");
    wait_code(1'b1);
    repeat (25) @(posedge i_clk);
    wr(4'h0, 32'h0000_20D1);
    evt(16'h5A3C);
    i_ctl.send(2'h1, 1'b1, 1'b0, 16'h1234, 2'h0, d);
    i_ctl.send(2'h1, 1'b1, 1'b0, 16'h0, 2'h0, d);
    repeat (2) @(posedge i_clk);
    #1 chk(o_evt_code, 16'h5A3C);
    i_ctl.send(2'h1, 1'b1, 1'b0, 16'h5A3C, 2'h0, d);
    repeat (2) @(posedge i_clk);
    #1 chk(o_evt_code, 16'h0);
    evt(16'h7777); chk(o_evt_code, 16'h0);
    wait_code(1'b0); chk(n >= 12, 1'b1);
    $display("test image clear done");
    rd(4'h3);
    wr(4'h4, 32'h1);
    #1 chk(o_irq, 1'b0);
    rd(4'h4); chk(q, 32'h1);
    wait_code(1'b1);
    repeat (25) @(posedge i_clk);
    evt(16'h0042);
    // the status bit follows the shown code by one cycle
    @(posedge i_clk); #1 chk(o_irq, 1'b1);
    rd(4'h2); chk(q, 32'h0000_0042);
    rd(4'h3); chk(q[2:0], 3'h3);
    #1 chk(o_irq, 1'b0);
    wr(4'h4, 32'h0);
    $display("test interrupt done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
